// ---- bei_error_irq.sv ----
`timescale 1ns/100ps
`default_nettype none

module bei_error_irq #(
  parameter bit SINGLE_PCI = 1'b0
) (
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  // Register bus
  input  wire bei_pkg::bei_avs_req_t avs_req_i,
  output bei_pkg::bei_avs_rsp_t      avs_rsp_o,
  // Latched error status word from the status block
  input  wire logic [31:0]           error_status_word_i,
  // Open-drain interrupt pins, low when driven
  output logic [7:0]                 int_pin_o,
  output logic [7:0]                 int_pin_oe_o,
  // Summary interrupt
  output logic                       irq_o
);
  import bei_pkg::*;

  // Writable bits of the enable word for this variant
  localparam logic [DATA_W-1:0] ENABLE_WR =
    SINGLE_PCI ? (ENABLE_IMPL & ~SECOND_PCI) : ENABLE_IMPL; // [R10]
  // Pin that only exists in the dual PCI variant
  localparam logic [PIN_N-1:0] PIN_WR =
    SINGLE_PCI ? 8'hfd : 8'hff; // [R10]

  bei_enable_t             error_enable_word;
  logic [DATA_W-1:0]       map_word [MAP_N];
  logic [PIN_N-1:0]        pin_dir;
  logic [PIN_N-1:0]        irq_status;
  logic [PIN_N-1:0]        irq_mask;
  logic [PIN_N-1:0]        pin_req_q;
  logic [DATA_W-1:0]       src_req;
  logic [PIN_N-1:0]        hit [SRC_N];
  logic [PIN_N-1:0]        pin_req;
  logic                    ack;
  logic                    access;
  logic                    wr_go;
  logic                    rd_go;
  logic [DATA_W-1:0]       wmask;
  logic [DATA_W-1:0]       next_rdata;
  logic [DATA_W-1:0]       rdata;

  // Bus handshake: one wait state, then the access completes
  assign access = avs_req_i.read | avs_req_i.write;
  assign wr_go  = avs_req_i.write & ack;
  assign rd_go  = avs_req_i.read & ~ack;
  assign avs_rsp_o.waitrequest = access & ~ack;
  assign avs_rsp_o.readdata    = rdata;

  // Byte lane mask from byteenable
  always_comb begin
    wmask = '0;
    for (int b = 0; b < BE_W; b++) begin
      wmask[b*8 +: 8] = {8{avs_req_i.byteenable[b]}};
    end
  end

  // Acknowledge flop, drops after each completed access
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= access & ~ack;
    end
  end

  // Enable word; reserved and absent-port bits never store
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      error_enable_word <= bei_enable_t'(ENABLE_RESET);
    end else if (wr_go && avs_req_i.address == OFF_ENABLE) begin
      // [R03] [R04] [R05] [R06] [R07] [R08] [R09] [R10]
      error_enable_word <= bei_enable_t'(
        (error_enable_word & ~(wmask & ENABLE_WR)) |
        (avs_req_i.writedata & wmask & ENABLE_WR));
    end
  end

  // Map words, one code per nibble
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int m = 0; m < MAP_N; m++) begin
        map_word[m] <= MAP_RESET;
      end
    end else if (wr_go) begin
      for (int m = 0; m < MAP_N; m++) begin
        if (avs_req_i.address == OFF_MAP0 + ADDR_W'(m * 4)) begin
          map_word[m] <= (map_word[m] & ~wmask) |
                         (avs_req_i.writedata & wmask);
        end
      end
    end
  end

  // Pin direction; a pin set to one is driven by this block
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_dir <= DIR_RESET;
    end else if (wr_go && avs_req_i.address == OFF_DIR &&
                 avs_req_i.byteenable[0]) begin
      pin_dir <= avs_req_i.writedata[PIN_N-1:0] & PIN_WR;
    end
  end

  // Summary interrupt mask
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_mask <= PIN_RESET;
    end else if (wr_go && avs_req_i.address == OFF_IRQ_MASK &&
                 avs_req_i.byteenable[0]) begin
      irq_mask <= avs_req_i.writedata[PIN_N-1:0];
    end
  end

  // Per-source request; enable only gates, status is untouched
  assign src_req = error_status_word_i & error_enable_word; // [R01] [R12]

  // One router per source
  for (genvar s = 0; s < SRC_N; s++) begin : g_src
    bei_route_slice #(
      .PINS  (PIN_N),
      .CODEW (CODE_W)
    ) u_slice (
      .req_i  (src_req[s]),
      .code_i (map_word[s / MAP_PER][(s % MAP_PER) * FIELD_W +: CODE_W]),
      .hit_o  (hit[s])
    );
  end

  // Merge hits per pin, gated by direction
  always_comb begin
    pin_req = '0;
    for (int s = 0; s < SRC_N; s++) begin
      pin_req = pin_req | hit[s];
    end
    pin_req = pin_req & pin_dir & PIN_WR; // [R02]
  end

  // Registered pin drive; open drain, so data is always low
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_req_q <= PIN_RESET;
    end else begin
      pin_req_q <= pin_req; // [R02]
    end
  end
  assign int_pin_o    = PIN_RESET;
  assign int_pin_oe_o = pin_req_q;

  // Sticky pin events on rising request; a new event beats the clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_status <= PIN_RESET;
    end else if (wr_go && avs_req_i.address == OFF_IRQ_STAT &&
                 avs_req_i.byteenable[0]) begin
      irq_status <= (irq_status & ~avs_req_i.writedata[PIN_N-1:0]) |
                    (pin_req & ~pin_req_q);
    end else begin
      irq_status <= irq_status | (pin_req & ~pin_req_q);
    end
  end

  // Summary level interrupt
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = ZERO_WORD;
    case (avs_req_i.address)
      OFF_ENABLE:   next_rdata = error_enable_word;
      OFF_STATUS:   next_rdata = error_status_word_i;
      OFF_MAP0:     next_rdata = map_word[0];
      OFF_MAP1:     next_rdata = map_word[1];
      OFF_MAP2:     next_rdata = map_word[2];
      OFF_MAP3:     next_rdata = map_word[3];
      OFF_DIR:      next_rdata = {24'h0, pin_dir};
      OFF_IRQ_STAT: next_rdata = {24'h0, irq_status};
      OFF_IRQ_MASK: next_rdata = {24'h0, irq_mask};
      OFF_PIN_REQ:  next_rdata = {24'h0, pin_req_q};
      default:      next_rdata = ZERO_WORD;
    endcase
  end

  // Read data captured in the wait cycle, stands at completion
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata <= ZERO_WORD;
    end else if (rd_go) begin
      rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ---- bei_pkg.sv ----
// Summary of operation
// R01: A latched error status bit raises an interrupt only while its enable bit in the enable register at 0x41c is one.
// R02: An enabled interrupt is driven onto the pin picked by the map and direction settings, never a fixed pin.
// R03: Byte 31-24 holds processor bus max-retry enables at 27, 26 and 25; bits 31-28 and 24 are reserved.
// R04: Processor bus error enables sit at 23, 22 and 21, and its address parity enable at 20.
// R05: Processor bus data parity enables sit at 19, 18 and 17; bit 16 is reserved and reads zero.
// R06: Second PCI error enables sit at 15, 14 and 13, and its address parity enable at 12.
// R07: Second PCI max-retry enables sit at 11, 10 and 9; bit 8 is reserved and reads zero.
// R08: First PCI error enables sit at 7, 6 and 5, and its address parity enable at 4.
// R09: First PCI max-retry enables sit at 3, 2 and 1; bit 0 is reserved and reads zero.
// R10: In the single PCI variant every enable touching the second PCI port is reserved.
// R11: A three-bit map code routes a source: 000 first PCI pin, 001 second PCI pin, 010-111 general pins 0-5.
// R12: Each request is status AND enable; clearing an enable masks it without touching the status.
`default_nettype none

package bei_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // Routing geometry
  localparam int SRC_N   = 32;
  localparam int PIN_N   = 8;
  localparam int CODE_W  = 3;
  localparam int FIELD_W = 4;
  localparam int MAP_N   = 4;
  localparam int MAP_PER = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ENABLE   = 12'h41c;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h440;
  localparam logic [ADDR_W-1:0] OFF_MAP0     = 12'h444;
  localparam logic [ADDR_W-1:0] OFF_MAP1     = 12'h448;
  localparam logic [ADDR_W-1:0] OFF_MAP2     = 12'h44c;
  localparam logic [ADDR_W-1:0] OFF_MAP3     = 12'h450;
  localparam logic [ADDR_W-1:0] OFF_DIR      = 12'h454;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h458;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h45c;
  localparam logic [ADDR_W-1:0] OFF_PIN_REQ  = 12'h460;

  // Reset values
  localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MAP_RESET    = 32'h0000_0000;
  localparam logic [PIN_N-1:0]  DIR_RESET    = 8'h00;
  localparam logic [PIN_N-1:0]  PIN_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_WORD    = 32'h0000_0000;

  // Implemented enable bits, and those tied to the second PCI port
  localparam logic [DATA_W-1:0] ENABLE_IMPL  = 32'h0efe_fefe;
  localparam logic [DATA_W-1:0] SECOND_PCI   = 32'h0444_fe88;

  // Map codes
  localparam logic [CODE_W-1:0] MAP_PCI1 = 3'h0;
  localparam logic [CODE_W-1:0] MAP_PCI2 = 3'h1;
  localparam logic [CODE_W-1:0] MAP_GEN0 = 3'h2;

  // Enable word layout, bit 31 first
  typedef struct packed {
    logic [3:0] rsvd_31_28;
    logic       procbus_retry_host1_enable;
    logic       procbus_retry_host2_enable;
    logic       procbus_retry_local_dma_enable;
    logic       rsvd_24;
    logic       procbus_fault_host1_enable;
    logic       procbus_fault_host2_enable;
    logic       procbus_fault_local_dma_enable;
    logic       procbus_addr_parity_enable;
    logic       procbus_data_parity_host1_enable;
    logic       procbus_data_parity_host2_enable;
    logic       procbus_data_parity_dma_enable;
    logic       rsvd_16;
    logic       second_pci_fault_from_first_enable;
    logic       second_pci_fault_from_procbus_enable;
    logic       second_pci_fault_dma_enable;
    logic       second_pci_addr_parity_enable;
    logic       second_pci_retry_from_first_enable;
    logic       second_pci_retry_from_procbus_enable;
    logic       second_pci_retry_dma_enable;
    logic       rsvd_8;
    logic       first_pci_fault_from_second_enable;
    logic       first_pci_fault_from_procbus_enable;
    logic       first_pci_fault_dma_enable;
    logic       first_pci_addr_parity_enable;
    logic       first_pci_retry_from_second_enable;
    logic       first_pci_retry_from_procbus_enable;
    logic       first_pci_retry_dma_enable;
    logic       rsvd_0;
  } bei_enable_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } bei_avs_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic              waitrequest;
    logic [DATA_W-1:0] readdata;
  } bei_avs_rsp_t;

endpackage

`default_nettype wire

// ---- bei_route_slice.sv ----
`timescale 1ns/100ps
`default_nettype none

module bei_route_slice #(
  parameter int PINS  = 8,
  parameter int CODEW = 3
) (
  // Source request and its map code
  input  wire logic             req_i,
  input  wire logic [CODEW-1:0] code_i,
  // One-hot pin hit
  output logic      [PINS-1:0]  hit_o
);

  // Decode code to one pin; codes past the pin count hit nothing
  always_comb begin
    hit_o = '0;
    for (int p = 0; p < PINS; p++) begin
      if (req_i && (code_i == CODEW'(p))) begin
        hit_o[p] = 1'b1; // [R11]
      end
    end
  end

endmodule

`default_nettype wire

// ---- bei_error_irq_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

module bei_error_irq_asserts #(
  parameter bit SINGLE_PCI = 1'b0
) (
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  srst_i,
  // Register bus
  input  wire bei_pkg::bei_avs_req_t avs_req_i,
  input  wire bei_pkg::bei_avs_rsp_t avs_rsp_o,
  // Status and pins
  input  wire logic [31:0]           error_status_word_i,
  input  wire logic [7:0]            int_pin_o,
  input  wire logic [7:0]            int_pin_oe_o,
  input  wire logic                  irq_o
);
  import bei_pkg::*;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // Request, wait and completion seen by the master
  logic rq;
  logic wq;
  logic rdy;
  assign rq  = avs_req_i.read | avs_req_i.write;
  assign wq  = avs_rsp_o.waitrequest;
  assign rdy = rq & ~wq;

  // One wait state per access, and a held request starts over
  wait_state_a: assert property (rq && wq |=> !wq)
    else $error("waitrequest high for more than one cycle");
  held_rerun_a: assert property (rdy |=> !rq || wq)
    else $error("held request completed without a new wait");
  // Open-drain data is always low; only the enable moves
  pin_data_a: assert property (int_pin_o == 8'h00)
    else $error("interrupt pin data not low");
  // No status means no request, whatever the enables hold
  mask_gate_a: assert property (
    error_status_word_i == 32'h0 |=> int_pin_oe_o == 8'h00)
    else $error("pin driven with no status bit set");
  single_pci_a: assert property (SINGLE_PCI |-> !int_pin_oe_o[1])
    else $error("second PCI pin driven in single variant");
  rsvd_zero_a: assert property (
    rdy && avs_req_i.read && avs_req_i.address == OFF_ENABLE
    |-> (avs_rsp_o.readdata & ~ENABLE_IMPL) == 32'h0)
    else $error("reserved enable bit reads one");
  unmapped_zero_a: assert property (
    rdy && avs_req_i.read && avs_req_i.address == 12'h000
    |-> avs_rsp_o.readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !avs_req_i.read |=> $stable(avs_rsp_o.readdata))
    else $error("read data moved without a read");

  // Main scenarios
  cov_enable_rd: cover property (rdy && avs_req_i.address == OFF_ENABLE);
  cov_pin_rise: cover property ($rose(|int_pin_oe_o));
  cov_irq_rise: cover property ($rose(irq_o));
endmodule

bind bei_error_irq bei_error_irq_asserts #(.SINGLE_PCI(SINGLE_PCI)) u_chk (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_req_i(avs_req_i),
  .avs_rsp_o(avs_rsp_o), .error_status_word_i(error_status_word_i),
  .int_pin_o(int_pin_o), .int_pin_oe_o(int_pin_oe_o), .irq_o(irq_o));

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import bei_pkg::*;

  logic         clk_sys_i;
  logic         srst_i;
  bei_avs_req_t req;
  bei_avs_rsp_t rsp;
  logic [31:0]  stat;
  logic [31:0]  q;
  logic [7:0]   pin;
  logic [7:0]   oe;
  logic         irq;
  bei_avs_rsp_t rsp_sp;
  logic [31:0]  q_sp;
  logic [7:0]   pin_sp;
  logic [7:0]   oe_sp;
  logic         irq_sp;
  int           error_cnt = 0;
  int           cmp_count = 0;
  int           cyc = 0;

  bei_error_irq #(.SINGLE_PCI(1'b0)) u_bei_error_irq (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_req_i(req),
    .avs_rsp_o(rsp), .error_status_word_i(stat), .int_pin_o(pin),
    .int_pin_oe_o(oe), .irq_o(irq));

  // Single PCI build on the same bus; its second PCI pin never drives
  bei_error_irq #(.SINGLE_PCI(1'b1)) u_bei_error_irq_single (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_req_i(req),
    .avs_rsp_o(rsp_sp), .error_status_word_i(stat), .int_pin_o(pin_sp),
    .int_pin_oe_o(oe_sp), .irq_o(irq_sp));

  // 25 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic results;
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access; an edge passes first so strobes never toggle twice
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys_i);
    req <= '{a, !w, w, d, be};
    do @(posedge clk_sys_i); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    q_sp = rsp_sp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask

  // Let the registered pin path land, then look off the edge
  task automatic settle;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic st(input logic [31:0] v);
    @(posedge clk_sys_i);
    stat <= v;
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // Main sequence
  initial begin
    req    = '0;
    stat   = 32'h0;
    srst_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(OFF_ENABLE, ENABLE_RESET);
    rd(12'h000, 32'h0);
    wr(OFF_ENABLE, 32'hffff_ffff);
    rd(OFF_ENABLE, ENABLE_IMPL);
    chk(q_sp, ENABLE_IMPL & ~SECOND_PCI);
    xfer(1'b1, OFF_ENABLE, 32'h0, 4'h1);
    rd(OFF_ENABLE, ENABLE_IMPL & 32'hffff_ff00);
    wr(OFF_DIR, 32'hff);
    rd(OFF_DIR, 32'hff);
    chk(q_sp, 32'hfd);
    st(32'hffff_ffff);
    // Each enable alone gates all-ones status onto pin 0
    for (int b = 0; b < 32; b++) begin
      wr(OFF_ENABLE, 32'h1 << b);
      settle();
      chk({24'h0, oe}, {31'h0, ENABLE_IMPL[b]});
      chk({24'h0, oe_sp}, {31'h0, ENABLE_IMPL[b] & ~SECOND_PCI[b]});
      chk({8'h0, pin, pin_sp, 8'h0}, 32'h0);
    end
    st(32'h2);
    wr(OFF_ENABLE, 32'h2);
    // Every map code for source 1
    for (int c = 0; c < 8; c++) begin
      wr(OFF_MAP0, 32'(c) << 4);
      settle();
      chk({24'h0, oe}, 32'h1 << c);
      chk({24'h0, oe_sp}, (c == 1) ? 32'h0 : 32'h1 << c);
    end
    rd(OFF_MAP0, 32'h70);
    wr(OFF_ENABLE, 32'h0);
    settle();
    chk({24'h0, oe}, 32'h0);
    rd(OFF_STATUS, 32'h2);
    wr(OFF_IRQ_STAT, 32'hff);
    wr(OFF_ENABLE, 32'h2);
    settle();
    rd(OFF_IRQ_STAT, 32'h80);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h80);
    settle();
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, irq_sp}, 32'h1);
    rd(OFF_IRQ_MASK, 32'h80);
    wr(OFF_IRQ_STAT, 32'h80);
    settle();
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, irq_sp}, 32'h0);
    rd(OFF_PIN_REQ, 32'h80);
    wr(OFF_DIR, 32'h0);
    settle();
    chk({24'h0, oe}, 32'h0);
    // Reset again in mid-run
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(OFF_ENABLE, ENABLE_RESET);
    results();
  end
endmodule

`default_nettype wire
